// *** hdl/cffim_pkg.sv ***
// Functional notes
// RQ1 - fault A bit 7 on battery-current loop change
// RQ2 - fault A bits 6,1,0 on input over-voltage
// RQ3 - fault A bit 5 on battery over-voltage
// RQ4 - fault A bit 4 on bus over-current
// RQ5 - fault A bit 3 on discharge over-current
// RQ6 - fault A bit 2 on converter over-current
// RQ7 - fault B bit 7 on system rail short
// RQ8 - fault B bit 6 on system rail over-voltage
// RQ9 - fault B bit 5 boost stopped, bus high
// RQ10 - fault B bit 4 boost stopped, bus low
// RQ11 - fault B bit 2 on overheat rise, reserved zero
// RQ12 - fault registers 0x26/0x27 read-only, reset zero
// RQ13 - mask 0x28 read/write, reset zero, 1 suppresses
// RQ14 - mask bit 7 gates current-limit loop entry
// RQ15 - mask bit 6 gates voltage-limit loop entry
// RQ16 - mask bit 5 gates watchdog expiry
// RQ17 - mask bit 4 gates weak source detection
// RQ18 - mask bit 3 gates power-good toggle
// RQ19 - mask bit 2 gates input B presence change
// RQ20 - mask bit 1 gates input A presence change
// RQ21 - mask bit 0 bus presence; register reset clears
// RQ22 - fault flags sticky until read, read clears
// RQ23 - unmasked event gives one pulse; flags always set
package cffim_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_FAULT_A = 8'h26;
    localparam logic [7:0] ADDR_FAULT_B = 8'h27;
    localparam logic [7:0] ADDR_MASK_A  = 8'h28;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_FAULT_A  = 8'h00;
    localparam logic [7:0] RST_FAULT_B  = 8'h00;
    localparam logic [7:0] RST_MASK_A   = 8'h00;
    localparam logic [7:0] RDATA_NONE   = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // fault A field positions
    localparam int A_BATT_LOOP   = 7;
    localparam int A_BUS_OV      = 6;
    localparam int A_BATT_OV     = 5;
    localparam int A_BUS_OC      = 4;
    localparam int A_DISCH_OC    = 3;
    localparam int A_CONV_OC     = 2;
    localparam int A_IN_B_OV     = 1;
    localparam int A_IN_A_OV     = 0;

    ////////////////////////////////////////////////////////////////////////
    // fault B field positions
    localparam int B_SYS_SHORT   = 7;
    localparam int B_SYS_OV      = 6;
    localparam int B_BOOST_OV    = 5;
    localparam int B_BOOST_UV    = 4;
    localparam int B_OVERHEAT    = 2;
    localparam logic [7:0] B_USED_BITS = 8'hF4;

    ////////////////////////////////////////////////////////////////////////
    // mask A field positions
    localparam int M_CURR_LOOP   = 7;
    localparam int M_VOLT_LOOP   = 6;
    localparam int M_WATCHDOG    = 5;
    localparam int M_WEAK_SRC    = 4;
    localparam int M_POWER_GOOD  = 3;
    localparam int M_IN_B_PRES   = 2;
    localparam int M_IN_A_PRES   = 1;
    localparam int M_BUS_PRES    = 0;

    ////////////////////////////////////////////////////////////////////////
    // rising-edge detector lanes
    localparam int RISE_LANES    = 18;
    localparam int R_SYS_SHORT   = 7;
    localparam int R_SYS_OV      = 8;
    localparam int R_BOOST_OV    = 9;
    localparam int R_BOOST_UV    = 10;
    localparam int R_OVERHEAT    = 11;
    localparam int R_IN_CURR     = 12;
    localparam int R_BOOST_CURR  = 13;
    localparam int R_IN_VOLT     = 14;
    localparam int R_BOOST_VOLT  = 15;
    localparam int R_WATCHDOG    = 16;
    localparam int R_WEAK_SRC    = 17;

    ////////////////////////////////////////////////////////////////////////
    // toggle detector lanes
    localparam int TOG_LANES     = 5;
    localparam int T_BATT_LOOP   = 0;
    localparam int T_POWER_GOOD  = 1;
    localparam int T_IN_B_PRES   = 2;
    localparam int T_IN_A_PRES   = 3;
    localparam int T_BUS_PRES    = 4;

endpackage

// *** hdl/cffim_edge.sv ***
`timescale 1ns/100ps
// per-lane change detector; first cycle after reset only arms
module cffim_edge #(
    parameter int WIDTH  = 1,
    parameter bit TOGGLE = 1'b0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // levels in, one-cycle events out
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] event_pulse
);

    typedef struct packed {
        logic             armed;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] evt;
    } cffim_edge_s;

    cffim_edge_s cur;
    cffim_edge_s next_cur;

    always_comb begin
        next_cur       = cur;
        next_cur.armed = 1'b1;
        next_cur.prev  = level;
        if (!cur.armed) begin
            next_cur.evt = '0;
        end else if (TOGGLE) begin
            next_cur.evt = level ^ cur.prev;
        end else begin
            next_cur.evt = level & ~cur.prev;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign event_pulse = cur.evt;

endmodule // cffim_edge

// *** hdl/cffim_top.sv ***
`timescale 1ns/100ps
module cffim_top (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // register port behind the host serial interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       reg_reset_cmd,
    // fault conditions, levels
    input  wire logic       batt_current_loop,
    input  wire logic       bus_overvolt,
    input  wire logic       batt_overvolt,
    input  wire logic       bus_overcurrent,
    input  wire logic       discharge_overcurrent,
    input  wire logic       converter_overcurrent,
    input  wire logic       input_b_overvolt,
    input  wire logic       input_a_overvolt,
    input  wire logic       sys_rail_short,
    input  wire logic       sys_rail_overvolt,
    input  wire logic       boost_out_overvolt,
    input  wire logic       boost_out_undervolt,
    input  wire logic       die_overheat,
    // charger conditions, levels
    input  wire logic       input_current_limit_loop,
    input  wire logic       boost_current_limit,
    input  wire logic       input_voltage_limit_loop,
    input  wire logic       boost_voltage_regulation,
    input  wire logic       watchdog_expired,
    input  wire logic       weak_source,
    input  wire logic       power_good,
    input  wire logic       input_b_present,
    input  wire logic       input_a_present,
    input  wire logic       bus_present,
    // host interrupt, active-low one-cycle pulse
    output logic            host_irq_b,
    // fault and mask register contents
    output logic      [7:0] fault_event_latch_a,
    output logic      [7:0] fault_event_latch_b,
    output logic      [7:0] irq_suppress_a
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] flag_a;
        logic [7:0] flag_b;
        logic [7:0] mask_a;
        logic [7:0] rdata;
        logic       rvalid;
        logic       irq_b;
    } cffim_state_s;

    cffim_state_s cur;
    cffim_state_s next_cur;

    logic [cffim_pkg::RISE_LANES-1:0] rise_level;
    logic [cffim_pkg::RISE_LANES-1:0] rise_evt;
    logic [cffim_pkg::TOG_LANES-1:0]  tog_level;
    logic [cffim_pkg::TOG_LANES-1:0]  tog_evt;
    logic [7:0]                       set_a;
    logic [7:0]                       set_b;
    logic [7:0]                       chg_evt;
    logic                             irq_hit;

    ////////////////////////////////////////////////////////////////////////
    // event detection

    always_comb begin
        rise_level = '0;
        rise_level[cffim_pkg::A_IN_A_OV]    = input_a_overvolt;
        rise_level[cffim_pkg::A_IN_B_OV]    = input_b_overvolt;
        rise_level[cffim_pkg::A_CONV_OC]    = converter_overcurrent;
        rise_level[cffim_pkg::A_DISCH_OC]   = discharge_overcurrent;
        rise_level[cffim_pkg::A_BUS_OC]     = bus_overcurrent;
        rise_level[cffim_pkg::A_BATT_OV]    = batt_overvolt;
        rise_level[cffim_pkg::A_BUS_OV]     = bus_overvolt;
        rise_level[cffim_pkg::R_SYS_SHORT]  = sys_rail_short;
        rise_level[cffim_pkg::R_SYS_OV]     = sys_rail_overvolt;
        rise_level[cffim_pkg::R_BOOST_OV]   = boost_out_overvolt;
        rise_level[cffim_pkg::R_BOOST_UV]   = boost_out_undervolt;
        rise_level[cffim_pkg::R_OVERHEAT]   = die_overheat;
        rise_level[cffim_pkg::R_IN_CURR]    = input_current_limit_loop;
        rise_level[cffim_pkg::R_BOOST_CURR] = boost_current_limit;
        rise_level[cffim_pkg::R_IN_VOLT]    = input_voltage_limit_loop;
        rise_level[cffim_pkg::R_BOOST_VOLT] = boost_voltage_regulation;
        rise_level[cffim_pkg::R_WATCHDOG]   = watchdog_expired;
        rise_level[cffim_pkg::R_WEAK_SRC]   = weak_source;
        tog_level = '0;
        tog_level[cffim_pkg::T_BATT_LOOP]   = batt_current_loop;
        tog_level[cffim_pkg::T_POWER_GOOD]  = power_good;
        tog_level[cffim_pkg::T_IN_B_PRES]   = input_b_present;
        tog_level[cffim_pkg::T_IN_A_PRES]   = input_a_present;
        tog_level[cffim_pkg::T_BUS_PRES]    = bus_present;
    end

    cffim_edge #(
        .WIDTH  (cffim_pkg::RISE_LANES),
        .TOGGLE (1'b0)
    ) u_rise (
        .clock       (clock),
        .rst_b       (rst_b),
        .level       (rise_level),
        .event_pulse (rise_evt)
    );

    cffim_edge #(
        .WIDTH  (cffim_pkg::TOG_LANES),
        .TOGGLE (1'b1)
    ) u_toggle (
        .clock       (clock),
        .rst_b       (rst_b),
        .level       (tog_level),
        .event_pulse (tog_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // event routing to flags and mask lanes

    always_comb begin
        set_a = '0;
        set_a[cffim_pkg::A_BATT_LOOP] = tog_evt[cffim_pkg::T_BATT_LOOP]; // RQ1
        set_a[cffim_pkg::A_BUS_OV]  = rise_evt[cffim_pkg::A_BUS_OV];     // RQ2
        set_a[cffim_pkg::A_IN_B_OV] = rise_evt[cffim_pkg::A_IN_B_OV];    // RQ2
        set_a[cffim_pkg::A_IN_A_OV] = rise_evt[cffim_pkg::A_IN_A_OV];    // RQ2
        set_a[cffim_pkg::A_BATT_OV] = rise_evt[cffim_pkg::A_BATT_OV];    // RQ3
        set_a[cffim_pkg::A_BUS_OC]  = rise_evt[cffim_pkg::A_BUS_OC];     // RQ4
        set_a[cffim_pkg::A_DISCH_OC] = rise_evt[cffim_pkg::A_DISCH_OC];  // RQ5
        set_a[cffim_pkg::A_CONV_OC] = rise_evt[cffim_pkg::A_CONV_OC];    // RQ6
        set_b = '0;
        set_b[cffim_pkg::B_SYS_SHORT] =
            rise_evt[cffim_pkg::R_SYS_SHORT];                            // RQ7
        set_b[cffim_pkg::B_SYS_OV]   = rise_evt[cffim_pkg::R_SYS_OV];    // RQ8
        set_b[cffim_pkg::B_BOOST_OV] = rise_evt[cffim_pkg::R_BOOST_OV];  // RQ9
        set_b[cffim_pkg::B_BOOST_UV] = rise_evt[cffim_pkg::R_BOOST_UV];  // RQ10
        set_b[cffim_pkg::B_OVERHEAT] = rise_evt[cffim_pkg::R_OVERHEAT];  // RQ11
        chg_evt = '0;
        chg_evt[cffim_pkg::M_CURR_LOOP] =
            rise_evt[cffim_pkg::R_IN_CURR] |
            rise_evt[cffim_pkg::R_BOOST_CURR];                            // RQ14
        chg_evt[cffim_pkg::M_VOLT_LOOP] =
            rise_evt[cffim_pkg::R_IN_VOLT] |
            rise_evt[cffim_pkg::R_BOOST_VOLT];                            // RQ15
        chg_evt[cffim_pkg::M_WATCHDOG] =
            rise_evt[cffim_pkg::R_WATCHDOG];                              // RQ16
        chg_evt[cffim_pkg::M_WEAK_SRC] =
            rise_evt[cffim_pkg::R_WEAK_SRC];                              // RQ17
        chg_evt[cffim_pkg::M_POWER_GOOD] =
            tog_evt[cffim_pkg::T_POWER_GOOD];                             // RQ18
        chg_evt[cffim_pkg::M_IN_B_PRES] =
            tog_evt[cffim_pkg::T_IN_B_PRES];                              // RQ19
        chg_evt[cffim_pkg::M_IN_A_PRES] =
            tog_evt[cffim_pkg::T_IN_A_PRES];                              // RQ20
        chg_evt[cffim_pkg::M_BUS_PRES] =
            tog_evt[cffim_pkg::T_BUS_PRES];                               // RQ21
        // fault events have no mask in this block
        irq_hit = (|(chg_evt & ~cur.mask_a)) | (|set_a) | (|set_b);      // RQ23
    end

    ////////////////////////////////////////////////////////////////////////
    // register access and flag update

    always_comb begin
        next_cur        = cur;
        next_cur.rvalid = 1'b0;
        next_cur.irq_b  = ~irq_hit;                                      // RQ23
        if (reg_rd) begin
            next_cur.rvalid = 1'b1;
            if (reg_addr == cffim_pkg::ADDR_FAULT_A) begin
                next_cur.rdata  = cur.flag_a;
                next_cur.flag_a = cffim_pkg::RST_FAULT_A;                // RQ22
            end else if (reg_addr == cffim_pkg::ADDR_FAULT_B) begin
                next_cur.rdata  = cur.flag_b & cffim_pkg::B_USED_BITS;   // RQ11
                next_cur.flag_b = cffim_pkg::RST_FAULT_B;                // RQ22
            end else if (reg_addr == cffim_pkg::ADDR_MASK_A) begin
                next_cur.rdata  = cur.mask_a;                            // RQ13
            end else begin
                next_cur.rdata  = cffim_pkg::RDATA_NONE;
            end
        end
        // writes to the fault registers are ignored
        if (reg_wr && (reg_addr == cffim_pkg::ADDR_MASK_A)) begin
            next_cur.mask_a = reg_wdata;                                 // RQ13
        end
        if (reg_reset_cmd) begin
            next_cur.mask_a = cffim_pkg::RST_MASK_A;                     // RQ21
        end
        // set wins over read-clear; masks never block flags
        next_cur.flag_a = next_cur.flag_a | set_a;                       // RQ22
        next_cur.flag_b = (next_cur.flag_b | set_b)
                          & cffim_pkg::B_USED_BITS;                      // RQ11
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur.flag_a <= cffim_pkg::RST_FAULT_A;                        // RQ12
            cur.flag_b <= cffim_pkg::RST_FAULT_B;                        // RQ12
            cur.mask_a <= cffim_pkg::RST_MASK_A;                         // RQ13
            cur.rdata  <= cffim_pkg::RDATA_NONE;
            cur.rvalid <= 1'b0;
            cur.irq_b  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata           = cur.rdata;
    assign reg_rvalid          = cur.rvalid;
    assign host_irq_b          = cur.irq_b;
    assign fault_event_latch_a = cur.flag_a;
    assign fault_event_latch_b = cur.flag_b;
    assign irq_suppress_a      = cur.mask_a;

endmodule // cffim_top

// *** verification/cffim_checker.sv ***
`timescale 1ns/100ps
module cffim_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       reg_reset_cmd,
    // watched conditions
    input wire logic       bus_overvolt,
    input wire logic       sys_rail_short,
    input wire logic       die_overheat,
    // results
    input wire logic       host_irq_b,
    input wire logic [7:0] fault_event_latch_a,
    input wire logic [7:0] fault_event_latch_b,
    input wire logic [7:0] irq_suppress_a
);
    ////////////////////////////////////////////////////////////////////////
    // edges since reset; detectors only arm on the first
    logic [1:0] live_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h2) begin
            live_q <= live_q + 2'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    a_no_stray: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    a_flag_readout: assert property (reg_rd &&
        reg_addr == cffim_pkg::ADDR_FAULT_A
        |=> reg_rdata == $past(fault_event_latch_a))
        else $error("read data not the flag value");
    a_reserved_zero: assert property (
        (fault_event_latch_b & 8'h0B) == 8'h00)
        else $error("reserved flag bit set");
    a_reset_cmd: assert property (
        reg_reset_cmd |=> irq_suppress_a == 8'h00)
        else $error("mask not cleared by reset command");
    a_mask_write: assert property (reg_wr && !reg_reset_cmd &&
        reg_addr == cffim_pkg::ADDR_MASK_A
        |=> irq_suppress_a == $past(reg_wdata))
        else $error("mask write lost");
    a_mask_hold: assert property (!reg_reset_cmd &&
        !(reg_wr && reg_addr == cffim_pkg::ADDR_MASK_A)
        |=> $stable(irq_suppress_a))
        else $error("mask changed without write");
    a_overvolt_flag: assert property (live_q == 2'h2 &&
        $rose(bus_overvolt) |-> ##2 fault_event_latch_a[6])
        else $error("over-voltage flag missing");
    a_overheat_flag: assert property (live_q == 2'h2 &&
        $rose(die_overheat) |-> ##2 fault_event_latch_b[2])
        else $error("overheat flag missing");
    a_short_irq: assert property (live_q == 2'h2 &&
        $rose(sys_rail_short) |-> ##2 !host_irq_b)
        else $error("rail short gave no interrupt");
endmodule // cffim_checker

bind cffim_top cffim_checker chk (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_reset_cmd(reg_reset_cmd),
    .bus_overvolt(bus_overvolt), .sys_rail_short(sys_rail_short),
    .die_overheat(die_overheat), .host_irq_b(host_irq_b),
    .fault_event_latch_a(fault_event_latch_a),
    .fault_event_latch_b(fault_event_latch_b),
    .irq_suppress_a(irq_suppress_a));

// *** verification/cffim_host.sv ***
`timescale 1ns/100ps
module cffim_host (
    // clock
    input  wire logic       clock,
    // register port towards the device
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    // interrupt line
    input  wire logic       host_irq_b
);
    int irq_count;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        irq_count = 0;
    end
    // one count per low cycle of the interrupt line
    always @(negedge clock) begin
        if (host_irq_b === 1'b0) begin
            irq_count++;
        end
    end
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule // cffim_host

// *** verification/cffim_top_test.sv ***
`timescale 1ns/100ps
module cffim_top_test;
    logic       clock;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       reg_reset_cmd;
    logic       host_irq_b;
    logic [7:0] fa;
    logic [7:0] fb;
    logic [7:0] cm;
    logic       boost_cur;
    logic       boost_volt;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] supp;
    int         fail_count;
    int         n_tests;
    int         bl[5] = '{7, 6, 5, 4, 2};
    localparam logic [7:0] FA = cffim_pkg::ADDR_FAULT_A;
    localparam logic [7:0] FB = cffim_pkg::ADDR_FAULT_B;
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    cffim_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .host_irq_b(host_irq_b));
    cffim_top uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_reset_cmd(reg_reset_cmd), .batt_current_loop(fa[7]),
        .bus_overvolt(fa[6]), .batt_overvolt(fa[5]),
        .bus_overcurrent(fa[4]), .discharge_overcurrent(fa[3]),
        .converter_overcurrent(fa[2]), .input_b_overvolt(fa[1]),
        .input_a_overvolt(fa[0]), .sys_rail_short(fb[7]),
        .sys_rail_overvolt(fb[6]), .boost_out_overvolt(fb[5]),
        .boost_out_undervolt(fb[4]), .die_overheat(fb[2]),
        .input_current_limit_loop(cm[7]), .boost_current_limit(boost_cur),
        .input_voltage_limit_loop(cm[6]),
        .boost_voltage_regulation(boost_volt), .watchdog_expired(cm[5]),
        .weak_source(cm[4]), .power_good(cm[3]), .input_b_present(cm[2]),
        .input_a_present(cm[1]), .bus_present(cm[0]),
        .host_irq_b(host_irq_b), .fault_event_latch_a(latch_a),
        .fault_event_latch_b(latch_b), .irq_suppress_a(supp));
    ////////////////////////////////////////////////////////////////////////
    task check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task checkn(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            fail_count++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        logic v;
        host.read_reg(a, d, v);
        check8("read answer", 8'h01, {7'h00, v});
    endtask
    task print_verdict;
        $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task reg_case;
        logic [7:0] d;
        rd(cffim_pkg::ADDR_FAULT_A, d);
        check8("fault a reset", 8'h00, d);
        rd(cffim_pkg::ADDR_FAULT_B, d);
        check8("fault b reset", 8'h00, d);
        rd(cffim_pkg::ADDR_MASK_A, d);
        check8("mask reset", 8'h00, d);
        host.write_reg(cffim_pkg::ADDR_FAULT_A, 8'hFF);
        host.write_reg(cffim_pkg::ADDR_FAULT_B, 8'hFF);
        rd(cffim_pkg::ADDR_FAULT_A, d);
        check8("fault a written", 8'h00, d);
        rd(cffim_pkg::ADDR_FAULT_B, d);
        check8("fault b written", 8'h00, d);
        rd(8'h30, d);
        check8("unmapped read", 8'h00, d);
        host.write_reg(cffim_pkg::ADDR_MASK_A, 8'hA5);
        rd(cffim_pkg::ADDR_MASK_A, d);
        check8("mask readback", 8'hA5, d);
        check8("mask output", 8'hA5, supp);
        reg_reset_cmd = 1'b1;
        cyc(1);
        reg_reset_cmd = 1'b0;
        rd(cffim_pkg::ADDR_MASK_A, d);
        check8("mask after reset cmd", 8'h00, d);
        // reset command and write land in one cycle
        host.write_reg(cffim_pkg::ADDR_MASK_A, 8'hFF);
        reg_reset_cmd = 1'b1;
        host.write_reg(cffim_pkg::ADDR_MASK_A, 8'h5A);
        reg_reset_cmd = 1'b0;
        check8("mask reset over write", 8'h00, supp);
    endtask
    task race_case;
        logic [7:0] d;
        // flag set and read-clear fall on one edge
        fa[5] = 1'b1;
        rd(FA, d);
        check8("read racing set", 8'h00, d);
        rd(FA, d);
        check8("set beats clear", 8'h20, d);
        fa[5] = 1'b0;
    endtask
    task reset_case;
        int c0;
        host.write_reg(cffim_pkg::ADDR_MASK_A, 8'hA5);
        fa[6] = 1'b1;
        cyc(3);
        rst_b = 1'b0;
        cyc(2);
        check8("flags in reset", 8'h00, latch_a | latch_b);
        check8("mask in reset", 8'h00, supp);
        check8("irq in reset", 8'h01, {7'h00, host_irq_b});
        c0 = host.irq_count;
        rst_b = 1'b1;
        cyc(3);
        check8("no event on arm", 8'h00, latch_a);
        fa[6] = 1'b0;
        cyc(3);
        checkn("pulses after reset", c0, host.irq_count);
    endtask
    task set_fault(input logic [7:0] a, input int i, input logic v);
        if (a == cffim_pkg::ADDR_FAULT_A) fa[i] = v;
        else fb[i] = v;
    endtask
    task fault_case(input logic [7:0] a, input int i, input logic tog);
        logic [7:0] d;
        int c0;
        c0 = host.irq_count;
        set_fault(a, i, 1'b1);
        cyc(3);
        check8("flag output", 8'h01 << i,
            a == FA ? latch_a : latch_b);
        rd(a, d);
        check8("flag set", 8'h01 << i, d);
        rd(a, d);
        check8("flag cleared", 8'h00, d);
        set_fault(a, i, 1'b0);
        cyc(3);
        rd(a, d);
        check8("flag after fall", tog ? 8'h01 << i : 8'h00, d);
        checkn("fault pulses", c0 + (tog ? 2 : 1), host.irq_count);
    endtask
    task src(input int s, input logic v);
        if (s < 8) cm[s] = v;
        else if (s == 8) boost_cur = v;
        else boost_volt = v;
    endtask
    task irq_case(input int s, input logic masked);
        logic [7:0] d;
        logic [7:0] m;
        int c0;
        m = 8'h01 << ((s < 8) ? s : 15 - s);
        if (!masked) m = ~m;
        host.write_reg(cffim_pkg::ADDR_MASK_A, m);
        rd(cffim_pkg::ADDR_MASK_A, d);
        check8("mask readback", m, d);
        c0 = host.irq_count;
        src(s, 1'b1);
        cyc(3);
        src(s, 1'b0);
        cyc(3);
        checkn("charger pulses", masked ? c0 : c0 + ((s < 4) ? 2 : 1),
            host.irq_count);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        n_tests = 0;
        rst_b = 1'b0;
        fa = 8'h00;
        fb = 8'h00;
        cm = 8'h00;
        boost_cur = 1'b0;
        boost_volt = 1'b0;
        reg_reset_cmd = 1'b0;
        cyc(6);
        rst_b = 1'b1;
        cyc(2);
        reg_case;
        race_case;
        reset_case;
        // fault events must ignore a full mask
        host.write_reg(cffim_pkg::ADDR_MASK_A, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            fault_case(FA, i, i == 7);
        end
        foreach (bl[k]) begin
            fault_case(FB, bl[k], 1'b0);
        end
        for (int s = 0; s < 10; s++) begin
            irq_case(s, 1'b0);
            irq_case(s, 1'b1);
        end
        print_verdict;
    end
    initial begin
        #400000;
        fail_count++;
        print_verdict;
    end
endmodule // cffim_top_test
